/* File: hdl/evsum_pkg.sv */
// shared constants and types for the event summary and interrupt block
package evsum_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_SUMMARY = 8'h00;
  localparam logic [7:0] CMD_MASK = 8'h01;
  localparam logic [7:0] CMD_POWER_EV = 8'h02;
  localparam logic [7:0] CMD_POWER_EV_COR = 8'h03;
  localparam logic [7:0] CMD_DETECT_EV = 8'h04;
  localparam logic [7:0] CMD_DETECT_EV_COR = 8'h05;
  localparam logic [7:0] CMD_FAULT_EV = 8'h06;
  localparam logic [7:0] CMD_FAULT_EV_COR = 8'h07;
  localparam logic [7:0] CMD_START_EV = 8'h08;
  localparam logic [7:0] CMD_START_EV_COR = 8'h09;
  localparam logic [7:0] CMD_SUPPLY_EV = 8'h0a;
  localparam logic [7:0] CMD_SUPPLY_EV_COR = 8'h0b;
  localparam logic [7:0] CMD_RESET = 8'h1a;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_SUPPLY = 7;
  localparam int BIT_START = 6;
  localparam int BIT_OVERCURRENT = 5;
  localparam int BIT_CLASS = 4;
  localparam int BIT_DETECT = 3;
  localparam int BIT_DISCONNECT = 2;
  localparam int BIT_PGOOD = 1;
  localparam int BIT_PENABLE = 0;
  localparam int BIT_RESET_CLEAR = 7;
  localparam logic [7:0] SUMMARY_RESET = 8'h80;
  localparam logic [7:0] MASK_RESET = 8'h80;
  localparam int NUM_CH = 4;

  // per-channel event flag pulses from the port engines
  typedef struct packed {
    logic [3:0] start_fault_ch;
    logic [3:0] overload_cut_ch;
    logic [3:0] current_limit_ch;
    logic [3:0] class_done_ch;
    logic [3:0] detect_done_ch;
    logic [3:0] disconnect_ch;
    logic [3:0] power_good_change_ch;
    logic [3:0] power_enable_change_ch;
  } chan_events_s;

  // device-wide supply fault pulses
  typedef struct packed {
    logic thermal_shutdown;
    logic digital_supply_undervolt;
    logic digital_supply_warning;
    logic power_supply_undervolt;
    logic code_memory_fault;
  } supply_events_s;

  // one register access from the serial front end
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } reg_access_s;

endpackage

/* File: hdl/evsum_flag.sv */
// one sticky event flag register of WIDTH bits with clear-on-read
`timescale 1ns/1ns
module evsum_flag
  import evsum_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [7:0] RESET_VAL = 8'h00
)
(
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic [WIDTH-1:0] set, // event pulses
  input wire logic clear, // clear all bits
  output logic [WIDTH-1:0] flags // sticky flags
);

  // ---------------------------------------------------------------
  // sticky bits
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] nxt_flags;

  // set wins over clear so a coincident event is kept
  always_comb
  begin
    nxt_flags = (clear ? '0 : flags_ff) | set;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_ff <= RESET_VAL[WIDTH-1:0];
    else
      flags_ff <= nxt_flags;
  end

  assign flags = flags_ff;

endmodule

/* File: hdl/pse_event_summary_irq.sv */
// event summary register, mask register and interrupt output logic
`timescale 1ns/1ns
module pse_event_summary_irq
  import evsum_pkg::*;
(
  input wire logic CLK, // 25 MHz system clock
  input wire logic NRST, // async active-low power-up reset
  input wire reg_access_s REG_ACC, // one-cycle register access
  input wire chan_events_s CH_EV, // per-channel event pulses
  input wire supply_events_s SUP_EV, // supply fault pulses
  input wire logic GLOBAL_IRQ_ENABLE, // global interrupt enable
  output logic [7:0] RDATA, // read data, valid cycle after rd
  output logic [7:0] MASK, // current mask register
  output logic INT_N // active-low interrupt output
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;

  // two stages so release is clean against CLK
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  assign rst_n = rst_sync_ff[1];

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic rd_pwr_cor;
  logic rd_det_cor;
  logic rd_flt_cor;
  logic rd_sta_cor;
  logic rd_sup_cor;
  logic wr_mask;
  logic global_clear;

  // only the clear-on-read codes and a 1ah write with bit 7 set clear, the plain reads do not
  always_comb
  begin
    rd_pwr_cor = 1'b0;
    rd_det_cor = 1'b0;
    rd_flt_cor = 1'b0;
    rd_sta_cor = 1'b0;
    rd_sup_cor = 1'b0;
    wr_mask = 1'b0;
    global_clear = 1'b0;
    if (REG_ACC.rd && REG_ACC.cmd == CMD_POWER_EV_COR)
      rd_pwr_cor = 1'b1;
    else if (REG_ACC.rd && REG_ACC.cmd == CMD_DETECT_EV_COR)
      rd_det_cor = 1'b1;
    else if (REG_ACC.rd && REG_ACC.cmd == CMD_FAULT_EV_COR)
      rd_flt_cor = 1'b1;
    else if (REG_ACC.rd && REG_ACC.cmd == CMD_START_EV_COR)
      rd_sta_cor = 1'b1;
    else if (REG_ACC.rd && REG_ACC.cmd == CMD_SUPPLY_EV_COR)
      rd_sup_cor = 1'b1;
    else if (REG_ACC.wr && REG_ACC.cmd == CMD_MASK)
      wr_mask = 1'b1;
    else if (REG_ACC.wr && REG_ACC.cmd == CMD_RESET)
      global_clear = REG_ACC.wdata[BIT_RESET_CLEAR];
  end

  // ---------------------------------------------------------------
  // per-channel and supply event registers
  // ---------------------------------------------------------------
  logic [7:0] pwr_ev;
  logic [7:0] det_ev;
  logic [7:0] flt_ev;
  logic [7:0] sta_ev;
  logic [4:0] sup_ev;

  // power good changes high nibble, enable changes low nibble
  evsum_flag #(.WIDTH(8), .RESET_VAL(8'h00)) u_pwr (
    .clk(CLK),
    .rst_n(rst_n),
    .set({CH_EV.power_good_change_ch, CH_EV.power_enable_change_ch}),
    .clear(rd_pwr_cor | global_clear),
    .flags(pwr_ev)
  );

  evsum_flag #(.WIDTH(8), .RESET_VAL(8'h00)) u_det (
    .clk(CLK),
    .rst_n(rst_n),
    .set({CH_EV.class_done_ch, CH_EV.detect_done_ch}),
    .clear(rd_det_cor | global_clear),
    .flags(det_ev)
  );

  evsum_flag #(.WIDTH(8), .RESET_VAL(8'h00)) u_flt (
    .clk(CLK),
    .rst_n(rst_n),
    .set({CH_EV.current_limit_ch, CH_EV.overload_cut_ch}),
    .clear(rd_flt_cor | global_clear),
    .flags(flt_ev)
  );

  // start faults low nibble, disconnects high nibble
  evsum_flag #(.WIDTH(8), .RESET_VAL(8'h00)) u_sta (
    .clk(CLK),
    .rst_n(rst_n),
    .set({CH_EV.disconnect_ch, CH_EV.start_fault_ch}),
    .clear(rd_sta_cor | global_clear),
    .flags(sta_ev)
  );

  // supply faults come up set after power-up
  evsum_flag #(.WIDTH(5), .RESET_VAL(8'h1f)) u_sup (
    .clk(CLK),
    .rst_n(rst_n),
    .set(SUP_EV),
    .clear(rd_sup_cor | global_clear),
    .flags(sup_ev)
  );

  // ---------------------------------------------------------------
  // summary byte
  // ---------------------------------------------------------------
  logic [7:0] summary;

  // pure OR of sources: a source read clears only its own bits
  always_comb
  begin
    summary = 8'h00;
    summary[BIT_SUPPLY] = |sup_ev;
    summary[BIT_START] = |sta_ev[3:0];
    summary[BIT_OVERCURRENT] = |flt_ev;
    summary[BIT_CLASS] = |det_ev[7:4];
    summary[BIT_DETECT] = |det_ev[3:0];
    summary[BIT_DISCONNECT] = |sta_ev[7:4];
    summary[BIT_PGOOD] = |pwr_ev[7:4];
    summary[BIT_PENABLE] = |pwr_ev[3:0];
  end

  // ---------------------------------------------------------------
  // mask, interrupt and read data registers
  // ---------------------------------------------------------------
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;
  logic int_n_ff;
  logic nxt_int_n;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] src_next;

  // interrupt uses flag state as it will stand after this edge,
  // so INT_N rises in the cycle the last cause goes away
  always_comb
  begin
    nxt_mask = wr_mask ? REG_ACC.wdata : mask_ff;
    src_next = 8'h00;
    src_next[BIT_SUPPLY] = |(((rd_sup_cor | global_clear) ? 5'h00 : sup_ev)
                             | SUP_EV);
    src_next[BIT_START] = |(((rd_sta_cor | global_clear) ? 4'h0
                           : sta_ev[3:0]) | CH_EV.start_fault_ch);
    src_next[BIT_DISCONNECT] = |(((rd_sta_cor | global_clear) ? 4'h0
                                : sta_ev[7:4]) | CH_EV.disconnect_ch);
    src_next[BIT_OVERCURRENT] = |(((rd_flt_cor | global_clear) ? 8'h00
                                 : flt_ev) | {CH_EV.current_limit_ch,
                                 CH_EV.overload_cut_ch});
    src_next[BIT_CLASS] = |(((rd_det_cor | global_clear) ? 4'h0
                           : det_ev[7:4]) | CH_EV.class_done_ch);
    src_next[BIT_DETECT] = |(((rd_det_cor | global_clear) ? 4'h0
                            : det_ev[3:0]) | CH_EV.detect_done_ch);
    src_next[BIT_PGOOD] = |(((rd_pwr_cor | global_clear) ? 4'h0
                           : pwr_ev[7:4]) | CH_EV.power_good_change_ch);
    src_next[BIT_PENABLE] = |(((rd_pwr_cor | global_clear) ? 4'h0
                             : pwr_ev[3:0]) | CH_EV.power_enable_change_ch);
    nxt_int_n = ~(GLOBAL_IRQ_ENABLE
                  & (|(src_next & nxt_mask)));
    nxt_rdata = rdata_ff;
    if (REG_ACC.rd)
    begin
      if (REG_ACC.cmd == CMD_SUMMARY)
        nxt_rdata = summary;
      else if (REG_ACC.cmd == CMD_MASK)
        nxt_rdata = mask_ff;
      else if (REG_ACC.cmd == CMD_POWER_EV || rd_pwr_cor)
        nxt_rdata = pwr_ev;
      else if (REG_ACC.cmd == CMD_DETECT_EV || rd_det_cor)
        nxt_rdata = det_ev;
      else if (REG_ACC.cmd == CMD_FAULT_EV || rd_flt_cor)
        nxt_rdata = flt_ev;
      else if (REG_ACC.cmd == CMD_START_EV || rd_sta_cor)
        nxt_rdata = sta_ev;
      else if (REG_ACC.cmd == CMD_SUPPLY_EV || rd_sup_cor)
        nxt_rdata = {3'b000, sup_ev};
      else
        nxt_rdata = 8'h00;
    end
  end

  // writes to 00h are not decoded, so it stays read-only
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_ff <= MASK_RESET;
      int_n_ff <= 1'b1;
      rdata_ff <= 8'h00;
    end
    else
    begin
      mask_ff <= nxt_mask;
      int_n_ff <= nxt_int_n;
      rdata_ff <= nxt_rdata;
    end
  end

  assign MASK = mask_ff;
  assign INT_N = int_n_ff;
  assign RDATA = rdata_ff;

endmodule

/* File: test/pse_event_summary_irq_monitor.sv */
// checker for summary flags, mask register and interrupt output
`timescale 1ns/1ns
module pse_event_summary_irq_monitor
  import evsum_pkg::*;
(
  input wire logic CLK, // clock
  input wire logic NRST, // async reset
  input wire reg_access_s REG_ACC, // register access
  input wire chan_events_s CH_EV, // channel events
  input wire supply_events_s SUP_EV, // supply events
  input wire logic GLOBAL_IRQ_ENABLE, // global enable
  input wire logic [7:0] RDATA, // read data
  input wire logic [7:0] MASK, // mask register
  input wire logic INT_N // interrupt output
);
  logic [2:0] rdy_ff;
  logic [7:0] ev_sum;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // wait out the internal reset synchroniser before judging anything
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      rdy_ff <= 3'h0;
    else
      rdy_ff <= {rdy_ff[1:0], 1'b1};
  end
  // which summary bits the current inputs would set
  assign ev_sum = {|SUP_EV, |CH_EV.start_fault_ch,
    |{CH_EV.overload_cut_ch, CH_EV.current_limit_ch},
    |CH_EV.class_done_ch, |CH_EV.detect_done_ch, |CH_EV.disconnect_ch,
    |CH_EV.power_good_change_ch, |CH_EV.power_enable_change_ch};
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST || !rdy_ff[2]);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_enable_gates_irq: assert property (!GLOBAL_IRQ_ENABLE |=> INT_N)
    else $error("interrupt active while globally disabled");
  a_mask_blocks_irq: assert property ((MASK == 8'h00
    && !REG_ACC.wr) |=> INT_N)
    else $error("interrupt active with mask all zero");
  a_event_drives_irq: assert property (((ev_sum & MASK) != 8'h00
    && GLOBAL_IRQ_ENABLE && !REG_ACC.wr) |=> !INT_N)
    else $error("unmasked event did not assert interrupt");
  a_mask_write_lands: assert property ((REG_ACC.wr &&
    REG_ACC.cmd == CMD_MASK) |=> MASK == $past(REG_ACC.wdata))
    else $error("mask write not taken");
  a_summary_read_only: assert property ((REG_ACC.wr &&
    REG_ACC.cmd == CMD_SUMMARY) |=> $stable(MASK))
    else $error("summary write disturbed mask");
  a_rdata_holds: assert property (!REG_ACC.rd |=> $stable(RDATA))
    else $error("read data changed without a read");
  a_reset_cmd_clears: assert property ((REG_ACC.wr &&
    REG_ACC.cmd == CMD_RESET && REG_ACC.wdata[7] && ev_sum == 8'h00)
    ##1 ev_sum == 8'h00 ##1 (REG_ACC.rd && REG_ACC.cmd == CMD_SUMMARY)
    |=> RDATA == 8'h00) else $error("reset command left summary bits");
  a_cor_read_clears: assert property ((REG_ACC.rd &&
    REG_ACC.cmd == CMD_DETECT_EV_COR && ev_sum == 8'h00)
    ##1 ev_sum == 8'h00 ##1 (REG_ACC.rd && REG_ACC.cmd == CMD_SUMMARY)
    |=> RDATA[4:3] == 2'b00) else $error("clear on read left bits");
  a_irq_release_fast: assert property ((!INT_N && REG_ACC.wr &&
    REG_ACC.cmd == CMD_RESET && REG_ACC.wdata[7] && ev_sum == 8'h00)
    |=> INT_N) else $error("interrupt held after last cause cleared");
endmodule

bind pse_event_summary_irq pse_event_summary_irq_monitor mon (.CLK, .NRST,
  .REG_ACC, .CH_EV, .SUP_EV, .GLOBAL_IRQ_ENABLE, .RDATA, .MASK, .INT_N);

/* File: test/evsum_host.sv */
// host model issuing single-byte register accesses
`timescale 1ns/1ns
module evsum_host
  import evsum_pkg::*;
(
  input wire logic CLK, // clock
  input wire logic [7:0] RDATA, // read data
  output reg_access_s REG_ACC // access strobe
);
  // ----------------------------------------------------------------
  // access
  // ----------------------------------------------------------------
  initial REG_ACC = '0;
  // one-cycle strobe; a write with bit 7 set to 1ah clears flags
  task automatic access(input logic rd, input logic [7:0] cmd,
    input logic [7:0] wdata, output logic [7:0] rdata);
    @(negedge CLK);
    REG_ACC = '{rd: rd, wr: !rd, cmd: cmd, wdata: wdata};
    @(negedge CLK);
    REG_ACC = '0;
    rdata = RDATA; // settled one edge after the strobe was taken
  endtask
endmodule

/* File: test/test_pse_event_summary_irq.sv */
// self-checking bench for the event summary and interrupt block
`timescale 1ns/1ns
module test_pse_event_summary_irq;
  import evsum_pkg::*;
  logic CLK, NRST, GLOBAL_IRQ_ENABLE, INT_N;
  reg_access_s REG_ACC;
  chan_events_s CH_EV;
  supply_events_s SUP_EV;
  logic [7:0] RDATA, MASK, rd_val;
  int num_errors = 0;
  int samples_checked = 0;
  // one source per row: event, summary bit, clear-on-read code, data
  logic [31:0] ev_t [9] = '{32'h0, 32'h8000_0000, 32'h0200_0000,
    32'h0040_0000, 32'h0001_0000, 32'h0000_2000, 32'h0000_0400,
    32'h0000_0080, 32'h0000_0001};
  logic [7:0] sum_t [9] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h10, 8'h08,
    8'h04, 8'h02, 8'h01};
  logic [7:0] cmd_t [9] = '{8'h0b, 8'h09, 8'h07, 8'h07, 8'h05, 8'h05,
    8'h09, 8'h03, 8'h03};
  logic [7:0] dat_t [9] = '{8'h01, 8'h08, 8'h02, 8'h40, 8'h10, 8'h02,
    8'h40, 8'h80, 8'h01};
  // ----------------------------------------------------------------
  // harness and tasks
  // ----------------------------------------------------------------
  pse_event_summary_irq uut (.CLK, .NRST, .REG_ACC, .CH_EV, .SUP_EV,
    .GLOBAL_IRQ_ENABLE, .RDATA, .MASK, .INT_N);
  evsum_host host (.CLK, .RDATA, .REG_ACC);
  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask
  task automatic rd(logic [7:0] c, logic [7:0] e, string n);
    host.access(1'b1, c, 8'h00, rd_val);
    check(n, rd_val, e);
  endtask
  task automatic wr(logic [7:0] c, logic [7:0] d);
    host.access(1'b0, c, d, rd_val);
  endtask
  // event inputs held one cycle only, so flags must be sticky
  task automatic pulse(logic [31:0] ev, logic [4:0] sup);
    @(negedge CLK);
    CH_EV = chan_events_s'(ev);
    SUP_EV = supply_events_s'(sup);
    @(negedge CLK);
    CH_EV = '0;
    SUP_EV = '0;
  endtask
  task automatic irq(logic e);
    check("INT_N", {7'h0, INT_N}, {7'h0, e});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    NRST = 1'b0;
    GLOBAL_IRQ_ENABLE = 1'b1;
    CH_EV = '0;
    SUP_EV = '0;
    repeat (16) @(negedge CLK);
    NRST = 1'b1;
    repeat (3) @(negedge CLK);
    irq(1'b0);
    rd(CMD_SUMMARY, SUMMARY_RESET, "summary");
    rd(CMD_MASK, MASK_RESET, "mask");
    wr(CMD_RESET, 8'h80);
    rd(CMD_SUMMARY, 8'h00, "summary");
    irq(1'b1);
    $display("test reset done");
    for (int i = 0; i < 9; i++)
    begin
      pulse(ev_t[i], (i == 0) ? 5'h01 : 5'h00);
      irq(i != 0);
      rd(CMD_SUMMARY, sum_t[i], "sum");
      rd(CMD_SUMMARY, sum_t[i], "sum");
      rd(cmd_t[i] - 8'h01, dat_t[i], "event");
      rd(cmd_t[i], dat_t[i], "clear_read");
      rd(CMD_SUMMARY, 8'h00, "sum");
      irq(1'b1);
    end
    $display("test sources done");
    wr(CMD_MASK, 8'h00);
    pulse(32'h0, 5'h10);
    irq(1'b1);
    wr(CMD_MASK, 8'hff);
    check("MASK", MASK, 8'hff);
    irq(1'b0);
    GLOBAL_IRQ_ENABLE = 1'b0;
    @(negedge CLK);
    irq(1'b1);
    GLOBAL_IRQ_ENABLE = 1'b1;
    @(negedge CLK);
    irq(1'b0);
    wr(CMD_SUMMARY, 8'h00);
    wr(CMD_RESET, 8'h7f);
    rd(CMD_SUMMARY, 8'h80, "sum");
    rd(CMD_MASK, 8'hff, "mask");
    rd(CMD_SUPPLY_EV_COR, 8'h10, "supply");
    irq(1'b1);
    // two causes pending: clearing one source keeps the other and the irq
    pulse(32'h8000_0001, 5'h00);
    irq(1'b0);
    rd(CMD_POWER_EV_COR, 8'h01, "clear_read");
    rd(CMD_SUMMARY, 8'h40, "sum");
    irq(1'b0);
    rd(CMD_START_EV_COR, 8'h08, "clear_read");
    irq(1'b1);
    rd(CMD_SUMMARY, 8'h00, "sum");
    rd(8'h7f, 8'h00, "unmapped");
    $display("test mask done");
    print_verdict();
  end
endmodule
